/* File: include/tpm_pkg.sv */
// package for the tos priority map: offsets, field layout, carriers
//
// ------------------------------------------------------------
// rule summary
// ------------------------------------------------------------
package tpm_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int          TPM_ADDR_W     = 8;
  localparam int          TPM_DATA_W     = 8;
  localparam int          TPM_NUM_BYTES  = 16;     // 0x60..0x6f cover all 64 codes
  localparam int          TPM_ENTRY_W    = 2;
  localparam int          TPM_NUM_CODES  = 64;
  localparam int          TPM_MAP_W      = 128;
  localparam logic [7:0]  TPM_BASE_OFS   = 8'h60;
  localparam logic [7:0]  TPM_BYTE0_OFS  = 8'h60;
  localparam logic [7:0]  TPM_BYTE1_OFS  = 8'h61;
  localparam logic [7:0]  TPM_BYTE2_OFS  = 8'h62;
  localparam logic [7:0]  TPM_BYTE3_OFS  = 8'h63;
  localparam logic [7:0]  TPM_BYTE_RST   = 8'h00;
  localparam logic [7:0]  TPM_UNMAPPED   = 8'h00;
  localparam int          TPM_CODE_LSB   = 2;      // dscp field sits in tos[7:2]
  localparam int          TPM_CODE_MSB   = 7;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tpm_bus_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] tos;
  } tpm_cls_req_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] prio;
  } tpm_cls_rsp_t;

endpackage

/* File: hw/tpm_top.sv */
// tos priority map: register bank and dscp to priority lookup
`timescale 1ns/1ps

module tpm_top (
  input  wire logic                  REF_CLK_I,  // 20 MHz core clock
  input  wire logic                  RSTN_I,     // async reset, active low
  input  wire tpm_pkg::tpm_bus_req_t BUS_REQ_I,  // register access
  output logic [7:0]                 BUS_RDATA_O,// read data, cycle after rd
  input  wire tpm_pkg::tpm_cls_req_t CLS_REQ_I,  // tos byte from parser
  output tpm_pkg::tpm_cls_rsp_t      CLS_RSP_O   // priority, one cycle later
);
  import tpm_pkg::*;

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0]           map_reg [TPM_NUM_BYTES];
  logic [TPM_MAP_W-1:0] map_flat;
  logic                 hit;
  logic [3:0]           idx;

  // byte index of an address inside the map window, and its hit flag
  function automatic logic [4:0] tpm_decode(input logic [7:0] a);
    logic [7:0] d;
    d = a - TPM_BASE_OFS;
    tpm_decode = {(a >= TPM_BASE_OFS) && (d < 8'(TPM_NUM_BYTES)), d[3:0]};
  endfunction

  assign {hit, idx} = tpm_decode(BUS_REQ_I.addr);

  // byte n lands on map bits [8n+7:8n]; code k thus on [2k+1:2k]
  always_comb begin
    for (int n = 0; n < TPM_NUM_BYTES; n++) begin
      map_flat[n*8 +: 8] = map_reg[n];
    end
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  // writes land at the edge, so the next frame already sees them
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int n = 0; n < TPM_NUM_BYTES; n++) begin
        map_reg[n] <= TPM_BYTE_RST;
      end
    end else if (BUS_REQ_I.wr && hit) begin
      map_reg[idx] <= BUS_REQ_I.wdata;
    end
  end

  // ------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------
  // reads only sample; unmapped addresses answer zero
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      BUS_RDATA_O <= TPM_UNMAPPED;
    end else if (BUS_REQ_I.rd) begin
      BUS_RDATA_O <= hit ? map_reg[idx] : TPM_UNMAPPED;
    end else begin
      BUS_RDATA_O <= TPM_UNMAPPED;
    end
  end

  // ------------------------------------------------------------
  // classification
  // ------------------------------------------------------------
  logic [5:0] code;
  assign code = CLS_REQ_I.tos[TPM_CODE_MSB:TPM_CODE_LSB];

  // registered lookup keeps the output straight from a flip-flop
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      CLS_RSP_O <= '0;
    end else begin
      CLS_RSP_O.valid <= CLS_REQ_I.valid;
      CLS_RSP_O.prio  <= map_flat[{code, 1'b0} +: TPM_ENTRY_W];
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);

  a_prio_lookup: assert property (
    CLS_REQ_I.valid |=> CLS_RSP_O.prio ==
      $past(map_flat[{CLS_REQ_I.tos[7:2], 1'b0} +: 2]))
    else $error("priority does not match map entry");

  a_byte0_low: assert property (
    CLS_REQ_I.valid && CLS_REQ_I.tos[7:2] == 6'h00 |=> CLS_RSP_O.prio == $past(map_reg[0][1:0]))
    else $error("code 0x00 not from byte 0x60 bits 1-0");

  a_byte1_field: assert property (
    CLS_REQ_I.valid && CLS_REQ_I.tos[7:2] == 6'h05 |=> CLS_RSP_O.prio == $past(map_reg[1][3:2]))
    else $error("code 0x05 not from byte 0x61 bits 3-2");

  a_byte2_high: assert property (
    CLS_REQ_I.valid && CLS_REQ_I.tos[7:2] == 6'h0b |=> CLS_RSP_O.prio == $past(map_reg[2][7:6]))
    else $error("code 0x0b not from byte 0x62 bits 7-6");

  a_byte3_top: assert property (
    CLS_REQ_I.valid && CLS_REQ_I.tos[7:2] == 6'h0f |=> CLS_RSP_O.prio == $past(map_reg[3][7:6]))
    else $error("code 0x0f not from byte 0x63 bits 7-6");

  a_byte3_low: assert property (
    CLS_REQ_I.valid && CLS_REQ_I.tos[7:2] == 6'h0d |=> CLS_RSP_O.prio == $past(map_reg[3][3:2]))
    else $error("code 0x0d not from byte 0x63 bits 3-2");

  a_upper_map: assert property (
    CLS_REQ_I.valid && CLS_REQ_I.tos[7:2] == 6'h10 |=> CLS_RSP_O.prio == $past(map_reg[4][1:0]))
    else $error("code 0x10 not from byte 0x64 bits 1-0");

  a_write_read: assert property (
    BUS_REQ_I.wr && hit ##1 BUS_REQ_I.rd && BUS_REQ_I.addr == $past(BUS_REQ_I.addr)
      |=> BUS_RDATA_O == $past(BUS_REQ_I.wdata, 2))
    else $error("read back differs from written byte");

  a_write_effect: assert property (
    BUS_REQ_I.wr && BUS_REQ_I.addr == TPM_BYTE0_OFS ##1
      CLS_REQ_I.valid && CLS_REQ_I.tos[7:2] == 6'h00 && !BUS_REQ_I.wr
      |=> CLS_RSP_O.prio == $past(BUS_REQ_I.wdata[1:0], 2))
    else $error("write not seen by next frame");

  a_valid_follow: assert property (
    CLS_RSP_O.valid == $past(CLS_REQ_I.valid))
    else $error("valid not one cycle behind request");

  c_write: cover property (BUS_REQ_I.wr && hit);
  c_read_back: cover property (BUS_REQ_I.wr && hit ##1 BUS_REQ_I.rd);
  c_nonzero: cover property (CLS_RSP_O.valid && CLS_RSP_O.prio == 2'h3);
  c_unmapped: cover property (BUS_REQ_I.rd && !hit);

endmodule

/* File: bench/tpm_parser_model.sv */
// parser-side partner that presents tos bytes to the priority map
`timescale 1ns/1ps

module tpm_parser_model
  import tpm_pkg::*;
(
  input  wire logic             clk_i,  // core clock
  input  wire logic             send_i, // present one frame
  input  wire logic [7:0]       tos_i,  // tos byte of that frame
  output tpm_pkg::tpm_cls_req_t req_o   // request toward the map
);
  logic [7:0] last_tos = 8'h00;
  initial req_o = '0;
  // between frames the tos lines carry junk, so a stale byte cannot pass
  always @(posedge clk_i) begin
    req_o.valid <= send_i;
    req_o.tos   <= send_i ? tos_i : ~last_tos;
    if (send_i) last_tos <= tos_i;
  end
endmodule

/* File: bench/tpm_top_tb.sv */
// self-checking bench for the tos priority map
`timescale 1ns/1ps

module tpm_top_tb;
  import tpm_pkg::*;
  logic         clk;
  logic         rstn = 1'b0;
  logic         send = 1'b0;
  logic [7:0]   tos = 8'h00;
  logic [7:0]   rdata;
  logic [7:0]   shd [16];
  tpm_bus_req_t bus = '0;
  tpm_cls_req_t req;
  tpm_cls_rsp_t rsp;
  int           mismatches = 0;
  int           cmp_count = 0;
  int           cyc = 0;
  // rows: address, write data, tos byte, expected priority
  logic [31:0]  rows [6] = '{32'h60e40401, 32'h611b1003, 32'h629c2c02,
                             32'h63c03f03, 32'h63393502, 32'h64804c02};

  tpm_top u_tpm_top (.REF_CLK_I(clk), .RSTN_I(rstn), .BUS_REQ_I(bus),
    .BUS_RDATA_O(rdata), .CLS_REQ_I(req), .CLS_RSP_O(rsp));
  tpm_parser_model u_tpm_parser_model (.clk_i(clk), .send_i(send), .tos_i(tos), .req_o(req));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // no gap: the caller's next strobe or an explicit idle replaces this one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    chk(rdata, e);
    @(posedge clk);
    @(negedge clk);
    chk(rdata, 8'h00);
    @(posedge clk);
  endtask
  // the partner adds one cycle, the map one more
  task automatic cls(input logic [7:0] t, input logic [1:0] e);
    send <= 1'b1;
    tos <= t;
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({5'h00, rsp.valid, rsp.prio}, {5'h00, 1'b1, e});
    @(posedge clk);
  endtask
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // roughly 340 cycles are needed; the ceiling leaves wide margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) rd(8'h60 + 8'(i), 8'h00);
    cls(8'hfc, 2'h0);
    foreach (rows[i]) begin
      wr(rows[i][31:24], rows[i][23:16]);
      rd(rows[i][31:24], rows[i][23:16]);
      cls(rows[i][15:8], rows[i][1:0]);
    end
    wr(8'h70, 8'hff);
    rd(8'h70, 8'h00);
    for (int i = 0; i < 16; i++) begin
      shd[i] = 8'h5a ^ 8'(i * 7);
      wr(8'h60 + 8'(i), shd[i]);
    end
    bus <= '0;
    @(posedge clk);
    for (int c = 0; c < 64; c++) cls({6'(c), 2'b11}, 2'(shd[c / 4] >> (2 * (c % 4))));
    // write and frame strobed in the same cycle: the frame must see the new byte
    bus <= '{8'h60, 8'h02, 1'b1, 1'b0};
    send <= 1'b1;
    tos <= 8'h00;
    @(posedge clk);
    bus <= '0;
    send <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({5'h00, rsp.valid, rsp.prio}, {5'h00, 1'b1, 2'h2});
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 16; i++) rd(8'h60 + 8'(i), 8'h00);
    cls(8'h3c, 2'h0);
    end_of_test();
  end
endmodule
